// file: ccu_channel.sv
// capture/compare channel with register port, interrupt and special event trigger
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps

// What this block does
// - four capture prescalers selected inside the four-bit mode field
// - prescaler counter held at zero when off or not capturing
// - changing prescaler keeps the count and may raise the flag
// - compare mode matches the 16-bit value against the selected timer pair
// - match drives output high, low, toggles or leaves it per mode
// - match sets the interrupt flag in the same cycle
// - writing zero to control forces the compare output latch low
// - software-interrupt compare only sets the flag
// - trigger compare emits a one-cycle internal trigger on match
// - trigger resets the currently selected timer pair
// - this channel's trigger never starts a conversion
// - capture copies the selected timer on the chosen edge event
// - capture sets a sticky flag; later captures overwrite the value
module ccu_channel #(
    parameter logic [3:0] CODE_CAP_FALL = ccu_pkg::MODE_CAP_FALL,
    parameter logic [3:0] CODE_CAP_RISE = ccu_pkg::MODE_CAP_RISE,
    parameter logic [3:0] CODE_CAP_RISE4 = ccu_pkg::MODE_CAP_RISE4,
    parameter logic [3:0] CODE_CAP_RISE16 = ccu_pkg::MODE_CAP_RISE16,
    parameter logic [3:0] CODE_CMP_HIGH = ccu_pkg::MODE_CMP_HIGH,
    parameter logic [3:0] CODE_CMP_LOW = ccu_pkg::MODE_CMP_LOW,
    parameter logic [3:0] CODE_CMP_TOGGLE = ccu_pkg::MODE_CMP_TOGGLE
) (
    input wire logic CLOCK_IN,
    input wire logic NRST_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [7:0] RDATA_OUT,
    input wire logic [15:0] TIMER_ONE_PAIR_IN,
    input wire logic [15:0] TIMER_THREE_PAIR_IN,
    input wire logic CHANNEL_PIN_IN,
    output logic CHANNEL_PIN_OUT,
    output logic COMPARE_ACTIVE_OUT,
    output logic TIMER_ONE_RESET_OUT,
    output logic TIMER_THREE_RESET_OUT,
    output logic ADC_START_OUT,
    output logic IRQ_OUT
);

    ccu_pkg::ccu_req_t req;
    logic [7:0] control_r;
    logic [15:0] value_r;
    logic [7:0] irq_flags_r;
    logic [7:0] irq_enables_r;
    logic [7:0] irq_prio_r;
    logic timer_sel_r;
    logic [3:0] prescale_r;
    logic [3:0] prescale_nxt;
    logic pin_meta_r;
    logic pin_sync_r;
    logic pin_prev_r;
    logic cmp_latch_r;
    logic cmp_latch_nxt;
    logic trig_one_r;
    logic trig_three_r;
    logic irq_r;
    logic [7:0] rdata_r;
    logic [3:0] mode;
    logic is_capture;
    logic is_compare;
    logic rise;
    logic fall;
    logic edge_hit;
    logic last_count;
    logic capture_now;
    logic [15:0] timer_sel_val;
    logic match;
    logic match_prev_r;
    logic match_event;
    logic flag_set;
    logic ctl_write;
    logic drive_mode;
    logic trig_fire;
    logic adc_start_r;

    assign req = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};
    assign mode = control_r[ccu_pkg::MODE_MSB:ccu_pkg::MODE_LSB];
    assign ctl_write = req.wr && (req.addr == ccu_pkg::ADDR_CONTROL);

    // decode table for capture and drive modes; software-interrupt and trigger codes fixed from the package
    always_comb begin
        is_capture = 1'b0;
        is_compare = 1'b0;
        drive_mode = 1'b0;
        case (mode)
            CODE_CAP_FALL, CODE_CAP_RISE, CODE_CAP_RISE4, CODE_CAP_RISE16: begin
                is_capture = 1'b1;
            end
            CODE_CMP_HIGH, CODE_CMP_LOW, CODE_CMP_TOGGLE: begin
                is_compare = 1'b1;
                drive_mode = 1'b1;
            end
            ccu_pkg::MODE_CMP_SWINT, ccu_pkg::MODE_CMP_TRIGGER: begin
                is_compare = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // pin is asynchronous to the core clock
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end else begin
            pin_meta_r <= CHANNEL_PIN_IN;
            pin_sync_r <= pin_meta_r;
        end
    end

    // edge history starts at the idle low level, so reset gives no false edge
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            pin_prev_r <= 1'b0;
        end else begin
            pin_prev_r <= pin_sync_r;
        end
    end

    assign rise = pin_sync_r && !pin_prev_r;
    assign fall = !pin_sync_r && pin_prev_r;
    assign timer_sel_val = timer_sel_r ? TIMER_THREE_PAIR_IN : TIMER_ONE_PAIR_IN;

    // edge choice and prescaler terminal count from the mode field
    always_comb begin
        edge_hit = 1'b0;
        last_count = 1'b0;
        case (mode)
            CODE_CAP_FALL: begin
                edge_hit = fall;
                last_count = 1'b1;
            end
            CODE_CAP_RISE: begin
                edge_hit = rise;
                last_count = 1'b1;
            end
            CODE_CAP_RISE4: begin
                edge_hit = rise;
                last_count = (prescale_r >= ccu_pkg::PRESCALE_DIV4_LAST);
            end
            CODE_CAP_RISE16: begin
                edge_hit = rise;
                last_count = (prescale_r == ccu_pkg::PRESCALE_DIV16_LAST);
            end
            default: begin
            end
        endcase
    end

    assign capture_now = is_capture && edge_hit && last_count;

    // count survives a prescaler change, so a partly advanced count may fire early
    always_comb begin
        prescale_nxt = prescale_r;
        if (!is_capture) begin
            prescale_nxt = ccu_pkg::PRESCALE_RST;
        end else if (capture_now) begin
            prescale_nxt = ccu_pkg::PRESCALE_RST;
        end else if (edge_hit) begin
            prescale_nxt = prescale_r + 4'h1;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            prescale_r <= ccu_pkg::PRESCALE_RST;
        end else begin
            prescale_r <= prescale_nxt;
        end
    end

    // match is edge-qualified so a stopped timer fires once, not every cycle
    assign match = is_compare && (value_r == timer_sel_val);
    assign match_event = match && !match_prev_r;

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            match_prev_r <= 1'b0;
        end else begin
            match_prev_r <= match;
        end
    end

    always_comb begin
        cmp_latch_nxt = cmp_latch_r;
        if (match_event) begin
            case (mode)
                CODE_CMP_HIGH: begin
                    cmp_latch_nxt = 1'b1;
                end
                CODE_CMP_LOW: begin
                    cmp_latch_nxt = 1'b0;
                end
                CODE_CMP_TOGGLE: begin
                    cmp_latch_nxt = !cmp_latch_r;
                end
                default: begin
                    cmp_latch_nxt = cmp_latch_r;
                end
            endcase
        end
        if (ctl_write && (req.wdata == ccu_pkg::CONTROL_RST)) begin
            cmp_latch_nxt = 1'b0;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            cmp_latch_r <= 1'b0;
        end else begin
            cmp_latch_r <= cmp_latch_nxt;
        end
    end

    // software-interrupt and trigger modes leave the latch alone
    assign trig_fire = match_event && (mode == ccu_pkg::MODE_CMP_TRIGGER);

    // only the timer that is the time base now gets cleared
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            trig_one_r <= 1'b0;
        end else begin
            trig_one_r <= trig_fire && !timer_sel_r;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            trig_three_r <= 1'b0;
        end else begin
            trig_three_r <= trig_fire && timer_sel_r;
        end
    end

    assign flag_set = capture_now || match_event;

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            control_r <= ccu_pkg::CONTROL_RST;
        end else if (ctl_write) begin
            control_r <= {2'b00, req.wdata[5:0]};
        end
    end

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            irq_enables_r <= ccu_pkg::IRQ_RST;
        end else if (req.wr && (req.addr == ccu_pkg::ADDR_IRQ_ENABLES)) begin
            irq_enables_r <= req.wdata;
        end
    end

    // stored only; priority is resolved by the interrupt controller outside
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            irq_prio_r <= ccu_pkg::IRQ_RST;
        end else if (req.wr && (req.addr == ccu_pkg::ADDR_IRQ_PRIORITIES)) begin
            irq_prio_r <= req.wdata;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            timer_sel_r <= 1'b0;
        end else if (req.wr && (req.addr == ccu_pkg::ADDR_TIMER_SEL)) begin
            timer_sel_r <= req.wdata[0];
        end
    end

    // capture wins over a same-cycle software write of the value
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            value_r <= ccu_pkg::VALUE_RST;
        end else if (capture_now) begin
            value_r <= timer_sel_val;
        end else if (req.wr && (req.addr == ccu_pkg::ADDR_VALUE_LOW)) begin
            value_r[7:0] <= req.wdata;
        end else if (req.wr && (req.addr == ccu_pkg::ADDR_VALUE_HIGH)) begin
            value_r[15:8] <= req.wdata;
        end
    end

    // write one to clear; a set in the same cycle wins
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            irq_flags_r <= ccu_pkg::IRQ_RST;
        end else begin
            if (req.wr && (req.addr == ccu_pkg::ADDR_IRQ_FLAGS)) begin
                irq_flags_r <= irq_flags_r & ~req.wdata;
            end
            if (flag_set) begin
                irq_flags_r[ccu_pkg::FLAG_CAPTURE] <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_flags_r & irq_enables_r);
        end
    end

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            rdata_r <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                ccu_pkg::ADDR_VALUE_LOW: begin
                    rdata_r <= value_r[7:0];
                end
                ccu_pkg::ADDR_VALUE_HIGH: begin
                    rdata_r <= value_r[15:8];
                end
                ccu_pkg::ADDR_CONTROL: begin
                    rdata_r <= control_r;
                end
                ccu_pkg::ADDR_IRQ_FLAGS: begin
                    rdata_r <= irq_flags_r;
                end
                ccu_pkg::ADDR_IRQ_ENABLES: begin
                    rdata_r <= irq_enables_r;
                end
                ccu_pkg::ADDR_IRQ_PRIORITIES: begin
                    rdata_r <= irq_prio_r;
                end
                ccu_pkg::ADDR_TIMER_SEL: begin
                    rdata_r <= {7'h00, timer_sel_r};
                end
                default: begin
                    rdata_r <= 8'h00;
                end
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    logic cmp_active_r;
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            cmp_active_r <= 1'b0;
        end else begin
            cmp_active_r <= drive_mode;
        end
    end

    // held low, but from a flop so every output leaves a register
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            adc_start_r <= 1'b0;
        end else begin
            adc_start_r <= 1'b0;
        end
    end

    assign RDATA_OUT = rdata_r;
    assign CHANNEL_PIN_OUT = cmp_latch_r;
    assign COMPARE_ACTIVE_OUT = cmp_active_r;
    assign TIMER_ONE_RESET_OUT = trig_one_r;
    assign TIMER_THREE_RESET_OUT = trig_three_r;
    assign ADC_START_OUT = adc_start_r;
    assign IRQ_OUT = irq_r;

endmodule : ccu_channel

// file: ccu_pkg.sv
// package: register map, mode codes and bundles for the capture/compare channel
package ccu_pkg;

    // register indices on the plain register port
    localparam logic [3:0] ADDR_VALUE_LOW = 4'h0;
    localparam logic [3:0] ADDR_VALUE_HIGH = 4'h1;
    localparam logic [3:0] ADDR_CONTROL = 4'h2;
    localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h3;
    localparam logic [3:0] ADDR_IRQ_ENABLES = 4'h4;
    localparam logic [3:0] ADDR_IRQ_PRIORITIES = 4'h5;
    localparam logic [3:0] ADDR_TIMER_SEL = 4'h6;

    // field positions
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 3;
    localparam int DUTY_LSB = 4;
    localparam int DUTY_MSB = 5;
    localparam int FLAG_CAPTURE = 0;

    // reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [15:0] VALUE_RST = 16'h0000;
    localparam logic [7:0] IRQ_RST = 8'h00;
    localparam logic [3:0] PRESCALE_RST = 4'h0;

    // prescaler terminal counts
    localparam logic [3:0] PRESCALE_DIV4_LAST = 4'h3;
    localparam logic [3:0] PRESCALE_DIV16_LAST = 4'hF;

    // operating mode codes
    typedef enum logic [3:0] {
        MODE_OFF = 4'h0,
        MODE_CMP_TOGGLE = 4'h2,
        MODE_CAP_FALL = 4'h4,
        MODE_CAP_RISE = 4'h5,
        MODE_CAP_RISE4 = 4'h6,
        MODE_CAP_RISE16 = 4'h7,
        MODE_CMP_HIGH = 4'h8,
        MODE_CMP_LOW = 4'h9,
        MODE_CMP_SWINT = 4'hA,
        MODE_CMP_TRIGGER = 4'hB
    } ccu_mode_t;

    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ccu_req_t;

endpackage : ccu_pkg

// file: ccu_chk.sv
// checker: port-level properties of the capture/compare channel
`timescale 1ns/10ps
module ccu_chk (
    input wire logic CLOCK_IN,
    input wire logic NRST_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [7:0] RDATA_OUT,
    input wire logic CHANNEL_PIN_OUT,
    input wire logic COMPARE_ACTIVE_OUT,
    input wire logic TIMER_ONE_RESET_OUT,
    input wire logic TIMER_THREE_RESET_OUT,
    input wire logic ADC_START_OUT
);
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (!NRST_IN);
    sequence ctl_wr(logic [3:0] m);
        WR_IN && ADDR_IN == ccu_pkg::ADDR_CONTROL && WDATA_IN == {4'h0, m};
    endsequence
    a_no_conversion: assert property (ADC_START_OUT == 1'b0)
        else $error("conversion start seen");
    a_trigger_one_shot: assert property ((TIMER_ONE_RESET_OUT || TIMER_THREE_RESET_OUT) |=>
        !(TIMER_ONE_RESET_OUT || TIMER_THREE_RESET_OUT)) else $error("trigger longer than one cycle");
    a_trigger_one_timer: assert property (!(TIMER_ONE_RESET_OUT && TIMER_THREE_RESET_OUT))
        else $error("both timers reset at once");
    // activity flag may lag the mode by a register, so allow two edges
    a_zero_clears_latch: assert property (ctl_wr(4'h0) |=> !CHANNEL_PIN_OUT ##1 !COMPARE_ACTIVE_OUT)
        else $error("zero control did not clear latch");
    a_high_mode_drives: assert property (ctl_wr(4'h8) |-> ##2 COMPARE_ACTIVE_OUT)
        else $error("drive mode not active");
    a_swint_no_drive: assert property (ctl_wr(4'hA) |-> ##2 !COMPARE_ACTIVE_OUT)
        else $error("software compare drives pin");
    // drive flag at this edge comes from the mode that could have moved the latch
    a_latch_holds: assert property (!COMPARE_ACTIVE_OUT && !$past(WR_IN) |->
        $stable(CHANNEL_PIN_OUT)) else $error("latch moved while not driving");
    a_read_idle_zero: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
        else $error("read data outside read slot");
    a_unmapped_zero: assert property (RD_IN && ADDR_IN > ccu_pkg::ADDR_TIMER_SEL |=> RDATA_OUT == 8'h00)
        else $error("unmapped read not zero");
    a_ctl_upper_zero: assert property (RD_IN && ADDR_IN == ccu_pkg::ADDR_CONTROL |=>
        RDATA_OUT[7:6] == 2'b00) else $error("control upper bits set");
endmodule : ccu_chk

bind ccu_channel ccu_chk i_ccu_chk (.CLOCK_IN(CLOCK_IN), .NRST_IN(NRST_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
    .CHANNEL_PIN_OUT(CHANNEL_PIN_OUT), .COMPARE_ACTIVE_OUT(COMPARE_ACTIVE_OUT),
    .TIMER_ONE_RESET_OUT(TIMER_ONE_RESET_OUT), .TIMER_THREE_RESET_OUT(TIMER_THREE_RESET_OUT),
    .ADC_START_OUT(ADC_START_OUT));

// file: ccu_timer_model.sv
// partner: the two timer pairs beside the channel
`timescale 1ns/10ps
module ccu_timer_model (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic run_in,
    input wire logic load_in,
    input wire logic [15:0] load_val_in,
    input wire logic clr_one_in,
    input wire logic clr_three_in,
    output logic [15:0] one_out,
    output logic [15:0] three_out
);
    // counts on the system clock only, never asynchronously
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            one_out <= 16'h0000;
            three_out <= 16'h0000;
        end else if (load_in) begin
            one_out <= load_val_in;
            three_out <= {load_val_in[7:0], load_val_in[15:8]};
        end else begin
            one_out <= clr_one_in ? 16'h0000 : one_out + 16'(run_in);
            three_out <= clr_three_in ? 16'h0000 : three_out + 16'(run_in);
        end
    end
endmodule : ccu_timer_model

// file: testbench.sv
// testbench: register-level tests of the capture/compare channel
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic pin = 1'b0;
    logic run = 1'b0;
    logic load = 1'b0;
    logic [15:0] load_val = 16'h0000;
    logic [7:0] rdata;
    logic [15:0] t1, t3;
    logic pin_out, act, r1, r3, adc, irq;
    // port direction bit: low lets the pad follow the compare latch
    logic port_direction_bit = 1'b1;
    wire pad_level = (act && !port_direction_bit) ? pin_out : pin;
    logic [3:0] modes [5] = '{4'h8, 4'h9, 4'h2, 4'h2, 4'h8};
    int err_count = 0;
    int num_checks = 0;
    int n;
    ccu_channel i_ccu_channel (.CLOCK_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata), .TIMER_ONE_PAIR_IN(t1),
        .TIMER_THREE_PAIR_IN(t3), .CHANNEL_PIN_IN(pin), .CHANNEL_PIN_OUT(pin_out),
        .COMPARE_ACTIVE_OUT(act), .TIMER_ONE_RESET_OUT(r1), .TIMER_THREE_RESET_OUT(r3),
        .ADC_START_OUT(adc), .IRQ_OUT(irq));
    ccu_timer_model i_ccu_timer_model (.clk_in(clk), .nrst_in(nrst), .run_in(run), .load_in(load),
        .load_val_in(load_val), .clr_one_in(r1), .clr_three_in(r3), .one_out(t1), .three_out(t3));
    always #2.5 clk = ~clk;
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk(16'(rdata), 16'(e));
    endtask : rd
    task automatic tload(input logic [15:0] v);
        @(posedge clk);
        load <= 1'b1;
        load_val <= v;
        @(posedge clk);
        load <= 1'b0;
    endtask : tload
    // pin held long enough to pass the two-flop synchroniser
    task automatic edges(input int k);
        repeat (k) begin
            @(posedge clk);
            pin <= 1'b1;
            repeat (6) @(posedge clk);
            pin <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask : edges
    initial begin
        #200000;
        err_count++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        rd(ccu_pkg::ADDR_CONTROL, 8'h00);
        rd(4'hF, 8'h00);
        wr(ccu_pkg::ADDR_VALUE_LOW, 8'h10);
        wr(ccu_pkg::ADDR_VALUE_HIGH, 8'h00);
        rd(ccu_pkg::ADDR_VALUE_LOW, 8'h10);
        wr(ccu_pkg::ADDR_CONTROL, 8'hF0);
        rd(ccu_pkg::ADDR_CONTROL, 8'h30);
        wr(ccu_pkg::ADDR_IRQ_PRIORITIES, 8'h5A);
        rd(ccu_pkg::ADDR_IRQ_PRIORITIES, 8'h5A);
        $display("test registers done");
        wr(ccu_pkg::ADDR_IRQ_ENABLES, 8'h01);
        run <= 1'b1;
        port_direction_bit <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            wr(ccu_pkg::ADDR_CONTROL, {4'h0, modes[i]});
            wr(ccu_pkg::ADDR_IRQ_FLAGS, 8'h01);
            tload(16'h0000);
            repeat (24) @(posedge clk);
            #1 chk(16'(pin_out), 16'(i % 2 == 0));
            chk(16'(irq), 16'h0001);
            chk(16'(pad_level), 16'(i % 2 == 0));
        end
        wr(ccu_pkg::ADDR_CONTROL, 8'h00);
        #1 chk(16'(pin_out), 16'h0000);
        wr(ccu_pkg::ADDR_IRQ_FLAGS, 8'h01);
        wr(ccu_pkg::ADDR_CONTROL, 8'h0A);
        tload(16'h0000);
        repeat (24) @(posedge clk);
        #1 chk(16'(pin_out), 16'h0000);
        chk(16'(irq), 16'h0001);
        chk(16'(pad_level), 16'h0000);
        wr(ccu_pkg::ADDR_IRQ_ENABLES, 8'h00);
        @(posedge clk);
        #1 chk(16'(irq), 16'h0000);
        rd(ccu_pkg::ADDR_IRQ_FLAGS, 8'h01);
        wr(ccu_pkg::ADDR_IRQ_FLAGS, 8'h01);
        rd(ccu_pkg::ADDR_IRQ_FLAGS, 8'h00);
        $display("test compare done");
        for (int s = 0; s < 2; s++) begin
            wr(ccu_pkg::ADDR_CONTROL, 8'h00);
            wr(ccu_pkg::ADDR_TIMER_SEL, 8'(s));
            wr(ccu_pkg::ADDR_CONTROL, 8'h0B);
            tload(16'h0000);
            n = 0;
            while (!(r1 || r3) && n < 40) begin
                @(posedge clk);
                #1 n++;
            end
            chk(16'({r3, r1}), 16'(s + 1));
            chk(16'(adc), 16'h0000);
            @(posedge clk);
            #1 chk(s ? t3 : t1, 16'h0000);
        end
        wr(ccu_pkg::ADDR_CONTROL, 8'h00);
        $display("test trigger done");
        run <= 1'b0;
        wr(ccu_pkg::ADDR_TIMER_SEL, 8'h00);
        wr(ccu_pkg::ADDR_CONTROL, 8'h05);
        tload(16'hABCD);
        wr(ccu_pkg::ADDR_IRQ_FLAGS, 8'h01);
        edges(1);
        rd(ccu_pkg::ADDR_VALUE_HIGH, 8'hAB);
        rd(ccu_pkg::ADDR_IRQ_FLAGS, 8'h01);
        wr(ccu_pkg::ADDR_CONTROL, 8'h00);
        wr(ccu_pkg::ADDR_CONTROL, 8'h04);
        tload(16'h1357);
        wr(ccu_pkg::ADDR_IRQ_FLAGS, 8'h01);
        edges(1);
        rd(ccu_pkg::ADDR_VALUE_LOW, 8'h57);
        wr(ccu_pkg::ADDR_CONTROL, 8'h00);
        wr(ccu_pkg::ADDR_CONTROL, 8'h06);
        wr(ccu_pkg::ADDR_IRQ_FLAGS, 8'h01);
        edges(2);
        wr(ccu_pkg::ADDR_CONTROL, 8'h00);
        wr(ccu_pkg::ADDR_CONTROL, 8'h06);
        wr(ccu_pkg::ADDR_IRQ_FLAGS, 8'h01);
        edges(3);
        rd(ccu_pkg::ADDR_IRQ_FLAGS, 8'h00);
        edges(1);
        rd(ccu_pkg::ADDR_IRQ_FLAGS, 8'h01);
        wr(ccu_pkg::ADDR_IRQ_FLAGS, 8'h01);
        edges(2);
        wr(ccu_pkg::ADDR_CONTROL, 8'h07);
        wr(ccu_pkg::ADDR_IRQ_FLAGS, 8'h01);
        edges(13);
        rd(ccu_pkg::ADDR_IRQ_FLAGS, 8'h00);
        edges(1);
        rd(ccu_pkg::ADDR_IRQ_FLAGS, 8'h01);
        $display("test capture done");
        final_report();
    end
endmodule : testbench
